//--- rtl/pisc_defines.vh
// constants of the interrupt aggregation and sideband control block
// assumes a 10 MHz system clock and a 9-bit register address
`ifndef PISC_DEFINES_VH
`define PISC_DEFINES_VH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define PISC_ADDR_IRQ_GROUP 9'h004
`define PISC_ADDR_IRQ_GROUP_MASK 9'h005
`define PISC_ADDR_CHIP_RESET_CONTROL 9'h006
`define PISC_ADDR_RTC_IRQ 9'h01C
`define PISC_ADDR_FAULT_IRQ 9'h030
`define PISC_ADDR_FAULT_MASK 9'h031
`define PISC_ADDR_ADC_IRQ 9'h05F
`define PISC_ADDR_ADC_MASK 9'h060
`define PISC_ADDR_CHG_IRQ 9'h0D0
`define PISC_ADDR_CHG_MASK 9'h0D1
`define PISC_ADDR_GPIO_IRQ 9'h0E8
`define PISC_ADDR_AUX_IRQ 9'h197
`define PISC_ADDR_AUX_MASK 9'h198

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PISC_RST_IRQ_GROUP_MASK 8'hFA
`define PISC_RST_FAULT_MASK 8'h03
`define PISC_RST_ADC_MASK 8'h00
`define PISC_RST_CHG_MASK 8'h00
`define PISC_RST_AUX_MASK 8'h0F
`define PISC_RST_CHIP_RESET_CONTROL 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PISC_BIT_COLD_RESTART 0
`define PISC_BIT_WARM_RESTART 1
`define PISC_BIT_GRP_BUTTON 0
`define PISC_BIT_GRP_EXTERNAL 7

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PISC_CLK_HZ 10000000
`define PISC_T_BUTTON_MS 10
`define PISC_T_OVP_RISE_MS 32
`define PISC_T_OVP_FALL_US 120
`define PISC_T_TEMP_MS 1
`define PISC_T_COMP_MS 1
`define PISC_T_USB_MS 10
`define PISC_T_BATT_MS 500
`define PISC_T_INPUT_CURRENT_CAP_MS 32
`define PISC_T_INOVP_MS 10
`define PISC_T_HEAT_MS 10
`define PISC_T_OCP_MS 1
`define PISC_T_VREG_ON_US 200
`define PISC_T_PRESS_MS 80
`define PISC_T_JACK_MS 30
`define PISC_T_RAIL_MIN_NS 500
`define PISC_T_RAIL_MAX_MS 30
`define PISC_T_PGOOD_US 100
`define PISC_T_RST_PULSE_S 8
`define PISC_CNT_W 28

`endif

//--- rtl/pisc_debounce.v
// two-flop synchroniser and stability filter for one event input
// assumes raw_i is asynchronous to clk_sys_i
`timescale 1ns/1ns
`include "pisc_defines.vh"

module pisc_debounce #(
  parameter [31:0] RISE_CNT = 32'd2,
  parameter [31:0] FALL_CNT = 32'd2
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // event input
  input wire raw_i,
  // filtered level and its edges
  output reg level_o,
  output reg rise_o,
  output reg fall_o
);

  reg sync1;
  reg sync2;
  reg [`PISC_CNT_W-1:0] cnt;
  wire [31:0] cnt_w = {{(32-`PISC_CNT_W){1'b0}}, cnt};
  wire [31:0] limit = sync2 ? (RISE_CNT - 32'd1) : (FALL_CNT - 32'd1);

  // ---------------------------------------------------------------
  // filter
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= {`PISC_CNT_W{1'b0}};
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      sync1 <= raw_i;
      sync2 <= sync1;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (sync2 == level_o) begin
        cnt <= {`PISC_CNT_W{1'b0}};
      end else if (cnt_w >= limit) begin
        level_o <= sync2;
        rise_o <= sync2;
        fall_o <= ~sync2;
        cnt <= {`PISC_CNT_W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

//--- rtl/pisc_irq_reg.v
// one 8-bit sticky interrupt register with clear on read
// assumes set inputs and read strobe come from logic on clk_sys_i
`timescale 1ns/1ns
`include "pisc_defines.vh"

module pisc_irq_reg (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // event sets
  input wire [7:0] edge_set_i,
  input wire [7:0] level_set_i,
  // read strobe of this register
  input wire rd_i,
  // stored bits
  output reg [7:0] q_o
);

  wire [7:0] captured = rd_i ? q_o : 8'h00;
  wire [7:0] level_now = rd_i ? 8'h00 : level_set_i;
  wire [7:0] next_q = (q_o & ~captured) | edge_set_i | level_now;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= 8'h00;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

//--- rtl/pisc_ctrl.v
// interrupt aggregation and sideband outputs of the power manager
// assumes register strobes come from the serial port logic on clk_sys_i
`timescale 1ns/1ns
`include "pisc_defines.vh"

module pisc_ctrl #(
  parameter [31:0] P_DEB_10MS = `PISC_T_BUTTON_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_32MS = `PISC_T_OVP_RISE_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_1MS = `PISC_T_TEMP_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_500MS = `PISC_T_BATT_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_OCP = `PISC_T_OCP_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_80MS = `PISC_T_PRESS_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_DEB_30MS = `PISC_T_JACK_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_RAIL_MAX = `PISC_T_RAIL_MAX_MS * (`PISC_CLK_HZ / 1000),
  parameter [31:0] P_RST_PULSE = `PISC_T_RST_PULSE_S * `PISC_CLK_HZ
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // register port
  input wire [8:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire vreg_wr_i,
  output reg [7:0] reg_rdata_o,
  // host pins
  input wire host_select_n_i,
  input wire standby_exit_in_i,
  output reg host_irq_out_o,
  output reg rail_done_out_o,
  output reg host_reset_n_o,
  output reg supply_valid_out_o,
  // rail status
  input wire rails_in_reg_i,
  input wire aon_rails_ok_i,
  // external event pins
  input wire button_event_i,
  input wire batt_overvolt_i,
  input wire batt_temp_i,
  input wire charge_done_i,
  input wire usb_attach_i,
  input wire batt_attach_i,
  input wire input_current_cap_i,
  input wire input_overvolt_i,
  input wire die_heat_warn_i,
  input wire batt_overcurrent_i,
  input wire regulator_fault_i,
  input wire long_press_i,
  input wire short_press_i,
  input wire headphone_sense_i,
  input wire headset_sense_i,
  // on-chip event sources
  input wire adc_cycle_done_i,
  input wire touch_wake_i,
  input wire coulomb_half_i,
  input wire rtc_update_flag_i,
  input wire rtc_alarm_flag_i,
  input wire update_irq_en_i,
  input wire alarm_irq_en_i,
  input wire [7:0] gpio_rise_i,
  input wire [7:0] gpio_fall_i,
  input wire [1:0] gpio_prevent_i
);

  // ---------------------------------------------------------------
  // derived counts
  // ---------------------------------------------------------------
  localparam [31:0] OVP_FALL_CNT = `PISC_T_OVP_FALL_US * (`PISC_CLK_HZ / 1000000);
  localparam [31:0] VRF_CNT = (`PISC_T_VREG_ON_US * 3 / 2) * (`PISC_CLK_HZ / 1000000);
  localparam [31:0] PG_CNT = `PISC_T_PGOOD_US * (`PISC_CLK_HZ / 1000000);
  localparam [31:0] RAIL_MIN = (`PISC_T_RAIL_MIN_NS * (`PISC_CLK_HZ / 1000000) + 999) / 1000;
  localparam [15*32-1:0] DB_RISE = {P_DEB_30MS, P_DEB_30MS, P_DEB_80MS, P_DEB_80MS,
    VRF_CNT, P_DEB_OCP, P_DEB_10MS, P_DEB_10MS, P_DEB_32MS, P_DEB_500MS,
    P_DEB_10MS, P_DEB_1MS, P_DEB_1MS, P_DEB_32MS, P_DEB_10MS};
  localparam [15*32-1:0] DB_FALL = {P_DEB_30MS, P_DEB_30MS, P_DEB_80MS, P_DEB_80MS,
    VRF_CNT, P_DEB_OCP, P_DEB_10MS, P_DEB_10MS, P_DEB_32MS, P_DEB_500MS,
    P_DEB_10MS, P_DEB_1MS, P_DEB_1MS, OVP_FALL_CNT, P_DEB_10MS};
  localparam RD_IDLE = 1'b0;
  localparam RD_HOLD = 1'b1;

  // ---------------------------------------------------------------
  // debounced external events
  // ---------------------------------------------------------------
  wire [14:0] ev_raw = {headset_sense_i, headphone_sense_i, short_press_i, long_press_i,
    regulator_fault_i, batt_overcurrent_i, die_heat_warn_i, input_overvolt_i,
    input_current_cap_i, batt_attach_i, usb_attach_i, charge_done_i, batt_temp_i,
    batt_overvolt_i, button_event_i};
  wire [14:0] ev_lvl;
  wire [14:0] ev_rise;
  wire [14:0] ev_fall;
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1) begin : g_deb
      pisc_debounce #(
        .RISE_CNT(DB_RISE[gi*32 +: 32]),
        .FALL_CNT(DB_FALL[gi*32 +: 32])
      ) u_deb (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .raw_i(ev_raw[gi]),
        .level_o(ev_lvl[gi]),
        .rise_o(ev_rise[gi]),
        .fall_o(ev_fall[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire rd_grp = reg_rd_i && (reg_addr_i == `PISC_ADDR_IRQ_GROUP);
  wire rd_rtc = reg_rd_i && (reg_addr_i == `PISC_ADDR_RTC_IRQ);
  wire rd_flt = reg_rd_i && (reg_addr_i == `PISC_ADDR_FAULT_IRQ);
  wire rd_adc = reg_rd_i && (reg_addr_i == `PISC_ADDR_ADC_IRQ);
  wire rd_chg = reg_rd_i && (reg_addr_i == `PISC_ADDR_CHG_IRQ);
  wire rd_gpio = reg_rd_i && (reg_addr_i == `PISC_ADDR_GPIO_IRQ);
  wire rd_aux = reg_rd_i && (reg_addr_i == `PISC_ADDR_AUX_IRQ);
  wire wr_ctl = reg_wr_i && (reg_addr_i == `PISC_ADDR_CHIP_RESET_CONTROL);
  reg [7:0] grp_mask;
  reg [7:0] flt_mask;
  reg [7:0] adc_mask;
  reg [7:0] chg_mask;
  reg [7:0] aux_mask;
  reg [1:0] chip_reset_control;

  // ---------------------------------------------------------------
  // second level sets
  // ---------------------------------------------------------------
  reg touch_prev;
  wire [7:0] adc_q;
  wire [7:0] chg_q;
  wire [7:0] rtc_q;
  wire [7:0] gpio_q;
  wire [7:0] flt_q;
  wire [7:0] aux_q;
  wire [7:0] grp_q;
  wire [7:0] adc_edge = {6'h00, touch_wake_i & ~touch_prev, 1'b0};
  wire [7:0] adc_lvl = {5'h00, coulomb_half_i, 1'b0, adc_cycle_done_i};
  wire [7:0] chg_edge = {3'h0, ev_rise[4] | ev_fall[4], ev_rise[3], 1'b0,
    ev_rise[1] | ev_fall[1], 1'b0};
  wire [7:0] chg_lvl = {ev_lvl[7], ev_lvl[6], ev_lvl[5], 2'h0, ev_lvl[2], 2'h0};
  wire rtc_irq_flag = (update_irq_en_i & rtc_update_flag_i) |
    (alarm_irq_en_i & rtc_alarm_flag_i);
  wire [7:0] rtc_lvl = {rtc_irq_flag, 1'b0, rtc_alarm_flag_i, rtc_update_flag_i, 4'h0};
  wire [7:0] gpio_edge = (gpio_prevent_i[0] ? 8'h00 : gpio_rise_i) |
    (gpio_prevent_i[1] ? 8'h00 : gpio_fall_i);
  wire [7:0] flt_lvl = {5'h00, ev_lvl[10], ev_lvl[9], ev_lvl[8]};
  wire [7:0] aux_edge = {4'h0, ev_rise[14] | ev_fall[14], ev_rise[13] | ev_fall[13],
    ev_rise[12], ev_rise[11]};

  pisc_irq_reg u_adc (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(adc_edge), .level_set_i(adc_lvl), .rd_i(rd_adc), .q_o(adc_q)
  );
  pisc_irq_reg u_chg (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(chg_edge), .level_set_i(chg_lvl), .rd_i(rd_chg), .q_o(chg_q)
  );
  pisc_irq_reg u_rtc (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(8'h00), .level_set_i(rtc_lvl), .rd_i(rd_rtc), .q_o(rtc_q)
  );
  pisc_irq_reg u_gpio (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(gpio_edge), .level_set_i(8'h00), .rd_i(rd_gpio), .q_o(gpio_q)
  );
  pisc_irq_reg u_flt (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(8'h00), .level_set_i(flt_lvl), .rd_i(rd_flt), .q_o(flt_q)
  );
  pisc_irq_reg u_aux (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(aux_edge), .level_set_i(8'h00), .rd_i(rd_aux), .q_o(aux_q)
  );

  // ---------------------------------------------------------------
  // first level and output pin
  // ---------------------------------------------------------------
  reg [6:1] or_prev;
  wire [6:1] or_now = {|aux_q, |flt_q, |gpio_q, |rtc_q, |chg_q, |adc_q};
  wire [7:0] grp_edge = {1'b0, or_now & ~or_prev, ev_fall[0]};
  wire [7:0] grp_open = {1'b0, |(aux_q & ~aux_mask), |(flt_q & ~flt_mask), 1'b1, 1'b1,
    |(chg_q & ~chg_mask), |(adc_q & ~adc_mask), 1'b1};

  pisc_irq_reg u_grp (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .edge_set_i(grp_edge), .level_set_i(8'h00), .rd_i(rd_grp), .q_o(grp_q)
  );

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      or_prev <= 6'h00;
      touch_prev <= 1'b0;
      host_irq_out_o <= 1'b0;
    end else begin
      or_prev <= or_now;
      touch_prev <= touch_wake_i;
      host_irq_out_o <= |(grp_q & ~grp_mask & grp_open);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      grp_mask <= `PISC_RST_IRQ_GROUP_MASK;
      flt_mask <= `PISC_RST_FAULT_MASK;
      adc_mask <= `PISC_RST_ADC_MASK;
      chg_mask <= `PISC_RST_CHG_MASK;
      aux_mask <= `PISC_RST_AUX_MASK;
      chip_reset_control <= 2'h0;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `PISC_ADDR_IRQ_GROUP_MASK: grp_mask <= reg_wdata_i;
          `PISC_ADDR_FAULT_MASK: flt_mask <= reg_wdata_i;
          `PISC_ADDR_ADC_MASK: adc_mask <= reg_wdata_i;
          `PISC_ADDR_CHG_MASK: chg_mask <= reg_wdata_i;
          `PISC_ADDR_AUX_MASK: aux_mask <= reg_wdata_i;
          `PISC_ADDR_CHIP_RESET_CONTROL: chip_reset_control <= reg_wdata_i[1:0];
          default: chip_reset_control <= chip_reset_control;
        endcase
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `PISC_ADDR_IRQ_GROUP: reg_rdata_o <= grp_q;
          `PISC_ADDR_IRQ_GROUP_MASK: reg_rdata_o <= grp_mask;
          `PISC_ADDR_CHIP_RESET_CONTROL: reg_rdata_o <= {6'h00, chip_reset_control};
          `PISC_ADDR_RTC_IRQ: reg_rdata_o <= rtc_q;
          `PISC_ADDR_FAULT_IRQ: reg_rdata_o <= flt_q;
          `PISC_ADDR_FAULT_MASK: reg_rdata_o <= flt_mask;
          `PISC_ADDR_ADC_IRQ: reg_rdata_o <= adc_q;
          `PISC_ADDR_ADC_MASK: reg_rdata_o <= adc_mask;
          `PISC_ADDR_CHG_IRQ: reg_rdata_o <= chg_q;
          `PISC_ADDR_CHG_MASK: reg_rdata_o <= chg_mask;
          `PISC_ADDR_GPIO_IRQ: reg_rdata_o <= gpio_q;
          `PISC_ADDR_AUX_IRQ: reg_rdata_o <= aux_q;
          `PISC_ADDR_AUX_MASK: reg_rdata_o <= aux_mask;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg [1:0] pin_prev;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1 <= 4'h1;
      pin_s2 <= 4'h1;
      pin_prev <= 2'h1;
    end else begin
      pin_s1 <= {aon_rails_ok_i, rails_in_reg_i, standby_exit_in_i, host_select_n_i};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2[1:0];
    end
  end
  wire sel_rise = pin_s2[0] & ~pin_prev[0];
  wire stby_rise = pin_s2[1] & ~pin_prev[1];
  wire rails_ok = pin_s2[2];
  wire aon_ok = pin_s2[3];

  // ---------------------------------------------------------------
  // rail done handshake
  // ---------------------------------------------------------------
  reg rd_state;
  reg vreg_pend;
  reg [`PISC_CNT_W-1:0] rail_cnt;
  wire [31:0] rail_cnt_w = {{(32-`PISC_CNT_W){1'b0}}, rail_cnt};
  wire rail_start = (sel_rise & vreg_pend) | stby_rise;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_state <= RD_IDLE;
      vreg_pend <= 1'b0;
      rail_cnt <= {`PISC_CNT_W{1'b0}};
      rail_done_out_o <= 1'b1;
    end else begin
      if (sel_rise) begin
        vreg_pend <= 1'b0;
      end else if (vreg_wr_i) begin
        vreg_pend <= 1'b1;
      end
      if (rail_start) begin
        rd_state <= RD_HOLD;
        rail_cnt <= {`PISC_CNT_W{1'b0}};
        rail_done_out_o <= 1'b0;
      end else begin
        case (rd_state)
          RD_IDLE: rail_done_out_o <= 1'b1;
          RD_HOLD: begin
            rail_cnt <= rail_cnt + 1'b1;
            if ((rail_cnt_w >= RAIL_MIN - 32'd1 && rails_ok) ||
                rail_cnt_w >= P_RAIL_MAX - 32'd1) begin
              rd_state <= RD_IDLE;
              rail_done_out_o <= 1'b1;
            end
          end
          default: rd_state <= RD_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // power good and restart pulses
  // ---------------------------------------------------------------
  reg [`PISC_CNT_W-1:0] pg_cnt;
  reg [`PISC_CNT_W-1:0] rst_cnt;
  reg rst_cold;
  wire [31:0] pg_cnt_w = {{(32-`PISC_CNT_W){1'b0}}, pg_cnt};
  wire cold_req = wr_ctl & reg_wdata_i[`PISC_BIT_COLD_RESTART];
  wire warm_req = wr_ctl & reg_wdata_i[`PISC_BIT_WARM_RESTART];
  wire rst_busy = (rst_cnt != {`PISC_CNT_W{1'b0}});
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pg_cnt <= {`PISC_CNT_W{1'b0}};
      rst_cnt <= {`PISC_CNT_W{1'b0}};
      rst_cold <= 1'b0;
      host_reset_n_o <= 1'b1;
      supply_valid_out_o <= 1'b0;
    end else begin
      if (!aon_ok) begin
        pg_cnt <= {`PISC_CNT_W{1'b0}};
      end else if (pg_cnt_w < PG_CNT) begin
        pg_cnt <= pg_cnt + 1'b1;
      end
      if (cold_req | warm_req) begin
        rst_cnt <= P_RST_PULSE[`PISC_CNT_W-1:0];
        rst_cold <= cold_req | (rst_cold & rst_busy);
      end else if (rst_busy) begin
        rst_cnt <= rst_cnt - 1'b1;
      end else begin
        rst_cold <= 1'b0;
      end
      host_reset_n_o <= ~(cold_req | warm_req | rst_busy);
      supply_valid_out_o <= aon_ok & (pg_cnt_w >= PG_CNT) & ~cold_req &
        ~(rst_cold & rst_busy);
    end
  end

endmodule

//--- test/pisc_ctrl_checker.sv
// concurrent checks on the sideband outputs of pisc_ctrl
// assumes a bind into pisc_ctrl, which hands on its timing parameters
`timescale 1ns/1ns
`include "pisc_defines.vh"
module pisc_ctrl_checker #(
  parameter [31:0] P_RAIL_MAX = 32'd200,
  parameter [31:0] P_RST_PULSE = 32'd50
) (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // watched ports
  input wire [8:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire aon_rails_ok_i,
  input wire host_reset_n_o,
  input wire supply_valid_out_o,
  input wire rail_done_out_o
);
  // ---------------------------------------------------------------
  // helpers and checks
  // ---------------------------------------------------------------
  localparam int RAIL_LIM = P_RAIL_MAX + 2;
  reg [10:0] aon_cnt;
  reg [31:0] low_cnt;
  wire rst_wr = reg_wr_i && (reg_addr_i == `PISC_ADDR_CHIP_RESET_CONTROL);
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aon_cnt <= 11'h000;
      low_cnt <= 32'h0;
    end else begin
      aon_cnt <= !aon_rails_ok_i ? 11'h000 : aon_cnt + {10'h000, aon_cnt != 11'h7FF};
      low_cnt <= host_reset_n_o ? 32'h0 : low_cnt + 32'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rail_low;
    !rail_done_out_o [*5];
  endsequence
  sequence s_rail_back;
    ##[1:RAIL_LIM] rail_done_out_o;
  endsequence
  chk_warm_pulse: assert property (rst_wr && reg_wdata_i[1] |-> ##[1:2] !host_reset_n_o)
    else $error("warm write did not pulse reset");
  chk_cold_pulse: assert property (rst_wr && reg_wdata_i[0] |->
    ##[1:2] (!host_reset_n_o && !supply_valid_out_o)) else $error("cold write did not pulse");
  chk_zero_write: assert property (rst_wr && reg_wdata_i[1:0] == 2'b00 && host_reset_n_o
    |=> host_reset_n_o [*2]) else $error("zero write changed reset");
  chk_pulse_width: assert property ($rose(host_reset_n_o) |-> low_cnt >= P_RST_PULSE)
    else $error("reset pulse too short");
  chk_rail_min: assert property ($fell(rail_done_out_o) |-> s_rail_low)
    else $error("rail done low too short");
  chk_rail_max: assert property ($fell(rail_done_out_o) |-> s_rail_back)
    else $error("rail done low too long");
  chk_pgood_rise: assert property ($rose(supply_valid_out_o) |-> aon_cnt >= 11'h3E8)
    else $error("power good before rails valid long enough");
  chk_pgood_drop: assert property (!aon_rails_ok_i [*5] |-> !supply_valid_out_o)
    else $error("power good kept after rail loss");
endmodule
bind pisc_ctrl pisc_ctrl_checker #(.P_RAIL_MAX(P_RAIL_MAX), .P_RST_PULSE(P_RST_PULSE))
  pisc_ctrl_checker_i (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .aon_rails_ok_i, .host_reset_n_o, .supply_valid_out_o, .rail_done_out_o);

//--- test/pisc_host_model.sv
// host model: ends a regulator write block by raising chip select
// assumes block_end_i is a one-cycle request on clk_sys_i
`timescale 1ns/1ns
module pisc_host_model (
  // clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // request and device answer
  input wire block_end_i,
  input wire rail_done_out_o,
  // chip select to the device
  output reg host_select_n_o
);
  reg [1:0] sel_cnt;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_select_n_o <= 1'b1;
      sel_cnt <= 2'h0;
    end else if (sel_cnt != 2'h0) begin
      sel_cnt <= sel_cnt - 2'h1;
      host_select_n_o <= (sel_cnt == 2'h1);
    end else if (block_end_i && rail_done_out_o) begin
      sel_cnt <= 2'h3;
      host_select_n_o <= 1'b0;
    end
  end
endmodule

//--- test/pisc_ctrl_tb.sv
// self-checking bench of pisc_ctrl with a chip select host model
// assumes the shortened counts set at the instance below
`timescale 1ns/1ns
`include "pisc_defines.vh"
module pisc_ctrl_tb;
  localparam int RSTP = 50;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, vreg_wr_i = 1'b0;
  logic [8:0] reg_addr_i = 9'h000;
  logic [7:0] reg_wdata_i = 8'h00, gpio_rise_i = 8'h00, gpio_fall_i = 8'h00, reg_rdata_o;
  logic [1:0] gpio_prevent_i = 2'h0;
  logic standby_exit_in_i = 1'b0, rails_in_reg_i = 1'b1, aon_rails_ok_i = 1'b1, blk = 1'b0;
  logic button_event_i = 1'b0, batt_overvolt_i = 1'b0, batt_temp_i = 1'b0, charge_done_i = 1'b0;
  logic usb_attach_i = 1'b0, batt_attach_i = 1'b0, input_current_cap_i = 1'b0;
  logic input_overvolt_i = 1'b0, die_heat_warn_i = 1'b0, batt_overcurrent_i = 1'b0;
  logic regulator_fault_i = 1'b0, long_press_i = 1'b0, short_press_i = 1'b0;
  logic headphone_sense_i = 1'b0, headset_sense_i = 1'b0, adc_cycle_done_i = 1'b0;
  logic touch_wake_i = 1'b0, coulomb_half_i = 1'b0, rtc_update_flag_i = 1'b0;
  logic rtc_alarm_flag_i = 1'b0, update_irq_en_i = 1'b0, alarm_irq_en_i = 1'b0;
  logic host_select_n_i, host_irq_out_o, rail_done_out_o, host_reset_n_o, supply_valid_out_o;
  int error_cnt = 0, tests_run = 0, cyc;
  always #50 clk_sys_i = ~clk_sys_i;
  pisc_ctrl #(.P_DEB_10MS(20), .P_DEB_32MS(30), .P_DEB_1MS(10), .P_DEB_500MS(40), .P_DEB_OCP(8),
    .P_DEB_80MS(25), .P_DEB_30MS(15), .P_RAIL_MAX(200), .P_RST_PULSE(RSTP)) pisc_ctrl_i (.*);
  pisc_host_model pisc_host_model_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .block_end_i(blk), .rail_done_out_o(rail_done_out_o), .host_select_n_o(host_select_n_i));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clk_sys_i) reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clk_sys_i) reg_rd_i = 1'b0;
    tk(1);
    cmp(reg_rdata_o, exp);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: pick = host_irq_out_o;
      1: pick = rail_done_out_o;
      2: pick = host_reset_n_o;
      default: pick = supply_valid_out_o;
    endcase
  endfunction
  task automatic lv(input int k, input logic v);
    cmp({7'h00, pick(k)}, {7'h00, v});
  endtask
  task automatic wf(input int k, input logic v, input int n);
    cyc = 0;
    while (pick(k) !== v) begin
      if (cyc == n) begin
        error_cnt++;
        $display("Error at %0t: timeout on output %0d", $time, k);
        print_verdict();
      end
      tk(1);
      cyc++;
    end
  endtask
  task automatic gp(input logic [7:0] m);
    @(negedge clk_sys_i) gpio_rise_i = m;
    @(negedge clk_sys_i) gpio_rise_i = 8'h00;
    tk(6);
  endtask
  task automatic pulse_blk(input logic with_vreg);
    @(negedge clk_sys_i) vreg_wr_i = with_vreg;
    @(negedge clk_sys_i) {vreg_wr_i, blk} = 2'b01;
    @(negedge clk_sys_i) blk = 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(`PISC_ADDR_IRQ_GROUP_MASK, 8'hFA);
    rd(`PISC_ADDR_CHIP_RESET_CONTROL, 8'h00);
    rd(`PISC_ADDR_FAULT_MASK, 8'h03);
    wr(`PISC_ADDR_IRQ_GROUP, 8'hFF);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h00);
    rd(9'h1FF, 8'h00);
  endtask
  task automatic t_gpio;
    gp(8'h01);
    lv(0, 1'b0);
    wr(`PISC_ADDR_IRQ_GROUP_MASK, 8'hEA);
    wf(0, 1'b1, 5);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h10);
    wf(0, 1'b0, 5);
    rd(`PISC_ADDR_GPIO_IRQ, 8'h01);
    gp(8'h02);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h10);
    gp(8'h04);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h00);
    rd(`PISC_ADDR_GPIO_IRQ, 8'h06);
    gpio_prevent_i = 2'h1;
    gp(8'h08);
    rd(`PISC_ADDR_GPIO_IRQ, 8'h00);
    gpio_prevent_i = 2'h0;
  endtask
  task automatic t_adc;
    wr(`PISC_ADDR_IRQ_GROUP_MASK, 8'hE8);
    wr(`PISC_ADDR_ADC_MASK, 8'h01);
    adc_cycle_done_i = 1'b1;
    tk(6);
    lv(0, 1'b0);
    wr(`PISC_ADDR_ADC_MASK, 8'h00);
    wf(0, 1'b1, 5);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h02);
    rd(`PISC_ADDR_ADC_IRQ, 8'h01);
    tk(4);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h02);
    adc_cycle_done_i = 1'b0;
    rd(`PISC_ADDR_ADC_IRQ, 8'h01);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h00);
    wf(0, 1'b0, 5);
  endtask
  task automatic t_button;
    button_event_i = 1'b1;
    tk(40);
    button_event_i = 1'b0;
    tk(10);
    button_event_i = 1'b1;
    tk(40);
    lv(0, 1'b0);
    button_event_i = 1'b0;
    wf(0, 1'b1, 40);
    cmp({7'h00, cyc > 20}, 8'h01);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h01);
    wf(0, 1'b0, 5);
  endtask
  task automatic t_rail;
    pulse_blk(1'b0);
    tk(8);
    lv(1, 1'b1);
    rails_in_reg_i = 1'b0;
    pulse_blk(1'b1);
    wf(1, 1'b0, 10);
    tk(12);
    lv(1, 1'b0);
    rails_in_reg_i = 1'b1;
    wf(1, 1'b1, 8);
    standby_exit_in_i = 1'b1;
    wf(1, 1'b0, 8);
    wf(1, 1'b1, 12);
    standby_exit_in_i = 1'b0;
  endtask
  task automatic t_restart;
    wf(3, 1'b1, 1100);
    wr(`PISC_ADDR_CHIP_RESET_CONTROL, 8'h02);
    tk(1);
    lv(2, 1'b0);
    lv(3, 1'b1);
    wf(2, 1'b1, RSTP + 3);
    cmp({7'h00, cyc >= RSTP - 3}, 8'h01);
    wr(`PISC_ADDR_CHIP_RESET_CONTROL, 8'h00);
    tk(4);
    lv(2, 1'b1);
    wr(`PISC_ADDR_CHIP_RESET_CONTROL, 8'h01);
    tk(1);
    lv(2, 1'b0);
    lv(3, 1'b0);
    wf(2, 1'b1, RSTP + 3);
    wf(3, 1'b1, 1100);
    aon_rails_ok_i = 1'b0;
    wf(3, 1'b0, 6);
  endtask
  task automatic t_src;
    {usb_attach_i, batt_attach_i, input_current_cap_i, input_overvolt_i, charge_done_i,
      batt_temp_i, die_heat_warn_i, batt_overcurrent_i, regulator_fault_i, long_press_i,
      short_press_i, headphone_sense_i, headset_sense_i, touch_wake_i, coulomb_half_i,
      rtc_update_flag_i, rtc_alarm_flag_i, update_irq_en_i} = '1;
    // regulator fault filter is the longest
    tk(3100);
    rd(`PISC_ADDR_IRQ_GROUP, 8'h6E);
    rd(`PISC_ADDR_CHG_IRQ, 8'hFC);
    rd(`PISC_ADDR_FAULT_IRQ, 8'h07);
    rd(`PISC_ADDR_AUX_IRQ, 8'h0F);
    rd(`PISC_ADDR_ADC_IRQ, 8'h06);
    rd(`PISC_ADDR_RTC_IRQ, 8'hB0);
  endtask
  initial begin
    tk(10);
    resetn_i = 1'b1;
    tk(1);
    t_regs();
    t_gpio();
    t_adc();
    t_button();
    t_src();
    t_rail();
    t_restart();
    print_verdict();
  end
endmodule
